// file: shared/tcc_pkg.sv
package tcc_pkg;
    // Channel count and counter width as built.
    localparam int CH_NUM = 6;
    localparam int CNT_W = 16;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_CH0 = 8'h26;
    localparam logic [7:0] IDX_CH1 = 8'h29;
    localparam logic [7:0] IDX_CH2 = 8'h2C;
    localparam logic [7:0] IDX_CH3 = 8'h2F;
    localparam logic [7:0] IDX_CH4 = 8'h32;
    localparam logic [7:0] IDX_CH5 = 8'h35;
    localparam logic [7:0] IDX_STATE = 8'h38;
    localparam logic [7:0] CH_IDX [0:5] = '{IDX_CH0, IDX_CH1, IDX_CH2,
                                            IDX_CH3, IDX_CH4, IDX_CH5};
    // Control register field positions.
    localparam int BIT_FLAG = 7;
    localparam int BIT_IE = 6;
    localparam int BIT_BUF = 5;
    localparam int BIT_FSA = 4;
    localparam int BIT_ELH = 3;
    localparam int BIT_ELL = 2;
    localparam int BIT_TOV = 1;
    localparam int BIT_MAX = 0;
    // Reset values.
    localparam logic [6:0] CTRL_RST = 7'h00;
    localparam logic LVL_RST = 1'h1;
    // Edge/level select codes.
    localparam logic [1:0] ELS_OFF = 2'h0;
    localparam logic [1:0] ELS_TOGGLE = 2'h1;
    localparam logic [1:0] ELS_CLEAR = 2'h2;
    localparam logic [1:0] ELS_SET = 2'h3;
endpackage

// file: hw/tcc_channel.sv
module tcc_channel #(
    parameter bit HAS_BUF = 1'b1,
    parameter int CNT_W = tcc_pkg::CNT_W
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [6:0] ctrl,
    input wire logic enable,
    input wire logic pin_level,
    input wire logic [CNT_W-1:0] cnt_value,
    input wire logic [CNT_W-1:0] cmp_value,
    input wire logic cnt_wrap,
    input wire logic counter_halt,
    output logic event_hit,
    output logic pin_out,
    output logic pin_oe
);
    logic [1:0] els;
    logic msb;
    logic active;
    logic cap_mode;
    logic cmp_mode;
    logic rise;
    logic fall;
    logic cap_ev;
    logic cmp_ev;
    logic wrap_tgl;
    logic pin_prev_r;
    logic match_prev_r;
    logic lvl_r;
    logic full_r;

    // Mode decode; a zero edge/level code parks the channel.
    assign els = ctrl[tcc_pkg::BIT_ELH:tcc_pkg::BIT_ELL];
    assign msb = HAS_BUF & ctrl[tcc_pkg::BIT_BUF];
    assign active = enable & (els != tcc_pkg::ELS_OFF);
    assign cap_mode = active & ~msb & ~ctrl[tcc_pkg::BIT_FSA];
    assign cmp_mode = active & (msb | ctrl[tcc_pkg::BIT_FSA]);
    assign rise = pin_level & ~pin_prev_r;
    assign fall = ~pin_level & pin_prev_r;
    // Captures are held off while the counter is halted.
    assign cap_ev = cap_mode & ~counter_halt & ((els[0] & rise) | (els[1] & fall));
    // A match counts once, on the cycle the counter arrives at the value.
    assign cmp_ev = cmp_mode & (cnt_value == cmp_value) & ~match_prev_r;
    assign wrap_tgl = cmp_mode & ctrl[tcc_pkg::BIT_TOV] & cnt_wrap;
    assign event_hit = cap_ev | cmp_ev;

    // Edge and match history.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pin_prev_r <= 1'h0;
            match_prev_r <= 1'h0;
        end else begin
            pin_prev_r <= pin_level;
            match_prev_r <= cnt_value == cmp_value;
        end
    end

    // Output level: preset while parked, overflow toggle beats a match.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            lvl_r <= tcc_pkg::LVL_RST;
        end else if (!active) begin
            lvl_r <= ~ctrl[tcc_pkg::BIT_FSA];
        end else if (wrap_tgl) begin
            lvl_r <= ~lvl_r;
        end else if (cmp_ev) begin
            unique case (els)
                tcc_pkg::ELS_TOGGLE: lvl_r <= ~lvl_r;
                tcc_pkg::ELS_CLEAR: lvl_r <= 1'h0;
                default: lvl_r <= 1'h1;
            endcase
        end
    end

    // Full duty is sampled at each wrap, so it acts from the next period.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            full_r <= 1'h0;
        end else if (cnt_wrap) begin
            full_r <= ctrl[tcc_pkg::BIT_MAX] & ~ctrl[tcc_pkg::BIT_TOV];
        end
    end

    // Pin drive registers; only compare modes drive the pin.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pin_out <= 1'h0;
            pin_oe <= 1'h0;
        end else begin
            pin_out <= (full_r & cmp_mode) | lvl_r;
            pin_oe <= cmp_mode;
        end
    end

    chk_tov_priority: assert property (@(posedge ref_clk) disable iff (!rstn)
        (wrap_tgl && cmp_ev) |=> (lvl_r != $past(lvl_r)))
        else $error("overflow toggle lost to compare");
    chk_preset_level: assert property (@(posedge ref_clk) disable iff (!rstn)
        !active |=> (lvl_r == !$past(ctrl[tcc_pkg::BIT_FSA])))
        else $error("preset level wrong");
    chk_rise_only: assert property (@(posedge ref_clk) disable iff (!rstn)
        (cap_mode && els == tcc_pkg::ELS_TOGGLE && fall) |-> !event_hit)
        else $error("falling edge captured in rising mode");
    chk_halt_blocks: assert property (@(posedge ref_clk) disable iff (!rstn)
        (cap_mode && counter_halt) |-> !event_hit)
        else $error("capture while halted");
    chk_oe_follow: assert property (@(posedge ref_clk) disable iff (!rstn)
        !active |=> !pin_oe)
        else $error("parked channel drives pin");
endmodule

// file: hw/tcc_timer_channels.sv
// Overview of operation
// - Capture edge on pin sets event flag.
// - Counter equal to compare sets flag.
// - Read-then-write-zero clears; new event keeps it.
// - Writing one no effect; reset clears flag.
// - Enabled flag raises channel interrupt request.
// - Buffered select exists on even channels only.
// - Even buffered select disables next odd channel.
// - Nonzero edge code: A picks capture/compare.
// - Zero edge code: A sets initial level.
// - Zero edge code releases pin to port.
// - Capture codes: rising, falling, either edge.
// - Compare codes: toggle, clear, set output.
// - Buffered select forces compare regardless of A.
// - Overflow toggle flips output in compare mode.
// - Overflow toggle beats simultaneous compare match.
// - Reset clears every control register bit.
// - Overflow is counter wrap after modulo.
// - Full duty force acts next period.
// - Halted counter suppresses input captures.
//
// Register access over AHB-Lite is this design's own decision.
module tcc_timer_channels #(
    parameter int NUM_CH = tcc_pkg::CH_NUM,
    parameter int CNT_W = tcc_pkg::CNT_W
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [CNT_W-1:0] cnt_value,
    input wire logic cnt_wrap,
    input wire logic counter_halt,
    input wire logic [NUM_CH*CNT_W-1:0] compare_value,
    input wire logic [NUM_CH-1:0] channel_pin_in,
    output logic [NUM_CH-1:0] channel_pin_out,
    output logic [NUM_CH-1:0] channel_pin_oe,
    output logic [NUM_CH-1:0] channel_irq
);
    // The register map and pairing serve an even count up to six.
    if (NUM_CH < 2 || NUM_CH > tcc_pkg::CH_NUM || NUM_CH % 2 != 0) begin : g_bad
        $error("NUM_CH must be even, 2 to 6");
    end

    logic acc;
    logic rd_acc;
    logic [7:0] acc_idx;
    logic wr_pend_r;
    logic [7:0] wr_idx_r;
    logic [7:0] rd_byte;
    logic [15:0] state_word;
    logic [NUM_CH-1:0] pin_s1_r;
    logic [NUM_CH-1:0] pin_s2_r;
    logic [NUM_CH-1:0] flag_r;
    logic [NUM_CH-1:0] arm_r;
    logic [NUM_CH-1:0] ev;
    logic [NUM_CH-1:0] odd_off;
    logic [NUM_CH-1:0] wr_hit;
    logic [NUM_CH-1:0] rd_hit;
    logic [NUM_CH-1:0] clr;
    logic [6:0] ctrl_r [NUM_CH];
    logic [7:0] view [NUM_CH];

    // Address phase decode; the word index is the byte address over four.
    assign acc = hsel & htrans[1] & hready;
    assign rd_acc = acc & ~hwrite;
    assign acc_idx = haddr[9:2];

    // The slave never stalls and always answers OKAY.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            hreadyout <= 1'h1;
            hresp <= 1'h0;
        end else begin
            hreadyout <= 1'h1;
            hresp <= 1'h0;
        end
    end

    // Writes are held over to the data phase, where hwdata stands.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            wr_pend_r <= 1'h0;
            wr_idx_r <= 8'h00;
        end else begin
            wr_pend_r <= acc & hwrite;
            if (acc) begin
                wr_idx_r <= acc_idx;
            end
        end
    end

    // Pin levels come from outside and pass two flip-flops first.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end else begin
            pin_s1_r <= channel_pin_in;
            pin_s2_r <= pin_s1_r;
        end
    end

    // Block state word: pin drive levels and pin ownership.
    assign state_word = {8'(channel_pin_oe), 8'(channel_pin_out)};

    // Read mux, built from the address phase so data is ready next cycle.
    always_comb begin
        rd_byte = 8'h00;
        for (int i = 0; i < NUM_CH; i++) begin
            if (rd_acc && acc_idx == tcc_pkg::CH_IDX[i]) begin
                rd_byte = view[i];
            end
        end
    end

    // Read data register; unmapped addresses read as zero.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            hrdata <= 32'h00000000;
        end else if (rd_acc && acc_idx == tcc_pkg::IDX_STATE) begin
            hrdata <= {16'h0000, state_word};
        end else begin
            hrdata <= {24'h000000, rd_byte};
        end
    end

    // Bus answers: the slave never waits and never reports an error.
    chk_bus_ready: assert property (@(posedge ref_clk) disable iff (!rstn)
        hreadyout && !hresp)
        else $error("slave stalled or erred");

    // Read data: the state word, zero when idle, upper half always zero.
    chk_state_read: assert property (@(posedge ref_clk) disable iff (!rstn)
        (rd_acc && acc_idx == tcc_pkg::IDX_STATE) |=> (hrdata[15:0] == $past(state_word)))
        else $error("state word read wrong");
    chk_idle_read_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
        !rd_acc |=> (hrdata == 32'h00000000))
        else $error("read data without a read");
    chk_upper_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
        hrdata[31:16] == 16'h0000)
        else $error("upper read data not zero");

    // Write capture: the address phase is held over for the data phase.
    chk_write_pend: assert property (@(posedge ref_clk) disable iff (!rstn)
        (acc && hwrite) |=> wr_pend_r)
        else $error("write not held over");
    chk_idx_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        acc |=> (wr_idx_r == $past(acc_idx)))
        else $error("write index not held");

    // The second synchroniser stage follows the first by one clock.
    chk_sync_stage: assert property (@(posedge ref_clk) disable iff (!rstn)
        1'b1 |=> (pin_s2_r == $past(pin_s1_r)))
        else $error("synchroniser stage skipped");

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        localparam bit IS_EVEN = (i % 2) == 0;
        localparam logic [6:0] WMASK = IS_EVEN ? 7'h7F : 7'h5F;

        // An odd channel is switched off by its even partner's buffer bit.
        if (IS_EVEN) begin : g_even
            assign odd_off[i] = 1'h0;
        end else begin : g_odd
            assign odd_off[i] = ctrl_r[i-1][tcc_pkg::BIT_BUF];
        end

        // Register view; a disabled odd channel reads as zero.
        assign view[i] = odd_off[i] ? 8'h00 : {flag_r[i], ctrl_r[i]};
        assign wr_hit[i] = wr_pend_r & (wr_idx_r == tcc_pkg::CH_IDX[i]) & ~odd_off[i];
        assign rd_hit[i] = rd_acc & (acc_idx == tcc_pkg::CH_IDX[i]) & ~odd_off[i];
        // A zero written to the flag clears it only after an armed read.
        assign clr[i] = wr_hit[i] & ~hwdata[tcc_pkg::BIT_FLAG] & arm_r[i];

        // Control bits; the odd channel's reserved bit never stores.
        always_ff @(posedge ref_clk) begin
            if (!rstn) begin
                ctrl_r[i] <= tcc_pkg::CTRL_RST;
            end else if (wr_hit[i]) begin
                ctrl_r[i] <= hwdata[6:0] & WMASK;
            end
        end

        // Event flag; a new event wins over a clear in the same cycle.
        always_ff @(posedge ref_clk) begin
            if (!rstn) begin
                flag_r[i] <= 1'h0;
            end else begin
                flag_r[i] <= ev[i] | (flag_r[i] & ~clr[i]);
            end
        end

        // Clear arming: set by a read that sees the flag, lost on an event.
        always_ff @(posedge ref_clk) begin
            if (!rstn) begin
                arm_r[i] <= 1'h0;
            end else if (ev[i] || wr_hit[i]) begin
                arm_r[i] <= 1'h0;
            end else if (rd_hit[i] && flag_r[i]) begin
                arm_r[i] <= 1'h1;
            end
        end

        // Interrupt request level from flag and enable.
        always_ff @(posedge ref_clk) begin
            if (!rstn) begin
                channel_irq[i] <= 1'h0;
            end else begin
                channel_irq[i] <= flag_r[i] & ctrl_r[i][tcc_pkg::BIT_IE];
            end
        end

        tcc_channel #(
            .HAS_BUF(IS_EVEN),
            .CNT_W(CNT_W)
        ) u_ch (
            .ref_clk(ref_clk),
            .rstn(rstn),
            .ctrl(ctrl_r[i]),
            .enable(~odd_off[i]),
            .pin_level(pin_s2_r[i]),
            .cnt_value(cnt_value),
            .cmp_value(compare_value[i*CNT_W +: CNT_W]),
            .cnt_wrap(cnt_wrap),
            .counter_halt(counter_halt),
            .event_hit(ev[i]),
            .pin_out(channel_pin_out[i]),
            .pin_oe(channel_pin_oe[i])
        );

        chk_flag_set: assert property (@(posedge ref_clk) disable iff (!rstn)
            ev[i] |=> flag_r[i])
            else $error("event did not set flag");
        chk_write_one: assert property (@(posedge ref_clk) disable iff (!rstn)
            (wr_hit[i] && hwdata[tcc_pkg::BIT_FLAG] && !flag_r[i] && !ev[i])
            |=> !flag_r[i])
            else $error("writing one set the flag");
        chk_clear_race: assert property (@(posedge ref_clk) disable iff (!rstn)
            (wr_hit[i] && !hwdata[tcc_pkg::BIT_FLAG] && ev[i]) |=> flag_r[i])
            else $error("event lost to clear");
        chk_clear_needs_arm: assert property (@(posedge ref_clk) disable iff (!rstn)
            (flag_r[i] && !arm_r[i]) |=> flag_r[i])
            else $error("flag cleared without read");
        chk_irq_raise: assert property (@(posedge ref_clk) disable iff (!rstn)
            (flag_r[i] && ctrl_r[i][tcc_pkg::BIT_IE]) |=> channel_irq[i])
            else $error("request missing");
        chk_irq_drop: assert property (@(posedge ref_clk) disable iff (!rstn)
            !(flag_r[i] && ctrl_r[i][tcc_pkg::BIT_IE]) |=> !channel_irq[i])
            else $error("request without flag and enable");
        chk_reset_clear: assert property (@(posedge ref_clk)
            !rstn |=> (ctrl_r[i] == tcc_pkg::CTRL_RST && !flag_r[i]))
            else $error("reset left control bits");

        // Flag and clear arming follow the read-then-write sequence.
        chk_flag_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
            (flag_r[i] && !clr[i]) |=> flag_r[i])
            else $error("flag dropped without clear");
        chk_clear_works: assert property (@(posedge ref_clk) disable iff (!rstn)
            (clr[i] && !ev[i]) |=> !flag_r[i])
            else $error("armed clear ignored");
        chk_arm_lost: assert property (@(posedge ref_clk) disable iff (!rstn)
            ev[i] |=> !arm_r[i])
            else $error("event left clear armed");
        chk_wr_disarm: assert property (@(posedge ref_clk) disable iff (!rstn)
            wr_hit[i] |=> !arm_r[i])
            else $error("write left clear armed");
        chk_arm_by_read: assert property (@(posedge ref_clk) disable iff (!rstn)
            (rd_hit[i] && flag_r[i] && !ev[i] && !wr_hit[i]) |=> arm_r[i])
            else $error("read of set flag did not arm");
        chk_flag_quiet: assert property (@(posedge ref_clk) disable iff (!rstn)
            (!flag_r[i] && !ev[i]) |=> !flag_r[i])
            else $error("flag set without event");

        // Control storage and read view.
        chk_ie_stored: assert property (@(posedge ref_clk) disable iff (!rstn)
            wr_hit[i] |=> (ctrl_r[i][tcc_pkg::BIT_IE] == $past(hwdata[tcc_pkg::BIT_IE])))
            else $error("enable bit not stored");
        chk_ctrl_kept: assert property (@(posedge ref_clk) disable iff (!rstn)
            !wr_hit[i] |=> $stable(ctrl_r[i]))
            else $error("control changed without write");
        chk_read_view: assert property (@(posedge ref_clk) disable iff (!rstn)
            rd_hit[i] |=> (hrdata[7:0] == $past(view[i])))
            else $error("register read wrong");

        // Request and pin ownership follow the registered state.
        chk_irq_masked: assert property (@(posedge ref_clk) disable iff (!rstn)
            !ctrl_r[i][tcc_pkg::BIT_IE] |=> !channel_irq[i])
            else $error("request while disabled");
        chk_irq_cause: assert property (@(posedge ref_clk) disable iff (!rstn)
            channel_irq[i] |-> $past(flag_r[i] && ctrl_r[i][tcc_pkg::BIT_IE]))
            else $error("request without cause");
        chk_pin_oe_mode: assert property (@(posedge ref_clk) disable iff (!rstn)
            channel_pin_oe[i] |-> ($past(ctrl_r[i][tcc_pkg::BIT_ELH:tcc_pkg::BIT_ELL])
            != tcc_pkg::ELS_OFF && !$past(odd_off[i])))
            else $error("parked channel owns pin");

        if (IS_EVEN) begin : g_even_chk
            chk_even_buf_store: assert property (@(posedge ref_clk) disable iff (!rstn)
                wr_hit[i] |=> (ctrl_r[i][tcc_pkg::BIT_BUF] == $past(hwdata[tcc_pkg::BIT_BUF])))
                else $error("buffered select not stored");
        end

        if (!IS_EVEN) begin : g_odd_chk
            chk_odd_reserved: assert property (@(posedge ref_clk) disable iff (!rstn)
                wr_hit[i] |=> !ctrl_r[i][tcc_pkg::BIT_BUF])
                else $error("reserved bit stored");
            chk_odd_release: assert property (@(posedge ref_clk) disable iff (!rstn)
                odd_off[i] [*2] |=> !channel_pin_oe[i])
                else $error("disabled channel drives pin");
            chk_odd_read_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
                (rd_acc && acc_idx == tcc_pkg::CH_IDX[i] && odd_off[i])
                |=> (hrdata == 32'h00000000))
                else $error("disabled channel reads nonzero");
            chk_odd_write_drop: assert property (@(posedge ref_clk) disable iff (!rstn)
                (wr_pend_r && wr_idx_r == tcc_pkg::CH_IDX[i] && odd_off[i])
                |=> $stable(ctrl_r[i]))
                else $error("disabled channel took write");
            chk_odd_bit_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
                (rd_acc && acc_idx == tcc_pkg::CH_IDX[i]) |=> !hrdata[tcc_pkg::BIT_BUF])
                else $error("reserved bit reads one");
        end
    end
endmodule

// file: verif/tcc_pin_model.sv
module tcc_pin_model (
    input wire logic [5:0] src_level,
    input wire logic [5:0] channel_pin_out,
    input wire logic [5:0] channel_pin_oe,
    output logic [5:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // A pin shows the timer level while the timer drives it, else the outside source.
    assign pin_level = (channel_pin_oe & channel_pin_out) | (~channel_pin_oe & src_level);
endmodule

// file: verif/test_timer_channel_capture_compare.sv
module test_timer_channel_capture_compare;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] idx; logic [7:0] wd; logic [7:0] exp;} tcc_row_t;
    logic ref_clk, rstn, hsel, hwrite, hready, hreadyout, hresp, cnt_wrap, counter_halt;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [15:0] cnt_value;
    logic [95:0] compare_value;
    logic [5:0] src_level, pin_in, pin_out, pin_oe, irq;
    logic [7:0] rd;
    int err_count, cmp_count;
    tcc_row_t rows [7] = '{'{8'h26, 8'h9C, 8'h1C}, '{8'h29, 8'hFF, 8'h5F},
        '{8'h2C, 8'hE3, 8'h63}, '{8'h2F, 8'h5C, 8'h00}, '{8'h32, 8'h2C, 8'h2C},
        '{8'h35, 8'h0C, 8'h00}, '{8'h27, 8'hFF, 8'h00}};
    logic [7:0] codes [4] = '{8'h1C, 8'h18, 8'h14, 8'h14};

    // The single slave's ready is the bus ready.
    assign hready = hreadyout;

    tcc_timer_channels u_tcc_timer_channels (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .cnt_value(cnt_value), .cnt_wrap(cnt_wrap), .counter_halt(counter_halt),
        .compare_value(compare_value), .channel_pin_in(pin_in), .channel_pin_out(pin_out),
        .channel_pin_oe(pin_oe), .channel_irq(irq));

    tcc_pin_model u_tcc_pin_model (.src_level(src_level), .channel_pin_out(pin_out),
        .channel_pin_oe(pin_oe), .pin_level(pin_in));

    // The clock toggles every 10 ns, a full period of 20 ns.
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // One single word transfer; read data is taken at the edge ending the data phase.
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        haddr <= {22'h000000, idx, 2'h0};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge ref_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h000000, wd};
        do @(posedge ref_clk); while (hready !== 1'b1);
        rd = hrdata[7:0];
    endtask

    // Compares one value and counts the outcome.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Lets a fixed number of clock edges pass.
    task automatic waitn(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Presents one counter value, optionally with a wrap pulse, then lets it settle.
    task automatic cnt(input logic [15:0] v, input logic w);
        cnt_value <= v;
        cnt_wrap <= w;
        @(posedge ref_clk);
        cnt_value <= 16'h0000;
        cnt_wrap <= 1'b0;
        waitn(4);
    endtask

    // Moves the outside level of pin 0 and waits past the input synchroniser.
    task automatic pin0(input logic lvl);
        src_level[0] <= lvl;
        waitn(6);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done;
        $display("errors=%0d checks=%0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Cuts a hung run short.
    initial begin
        waitn(20000);
        err_count++;
        test_done();
    end

    // Main sequence.
    initial begin
        rstn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h00000000;
        cnt_value = 16'h0000;
        cnt_wrap = 1'b0;
        counter_halt = 1'b0;
        compare_value = {6{16'h0010}};
        src_level = 6'h00;
        err_count = 0;
        cmp_count = 0;
        waitn(10);
        rstn <= 1'b1;
        hsel <= 1'b1;
        waitn(1);
        foreach (rows[i]) begin
            bus(1'b1, rows[i].idx, rows[i].wd);
            bus(1'b0, rows[i].idx, 8'h00);
            chk(rd, rows[i].exp);
        end
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, tcc_pkg::CH_IDX[i], 8'h00);
        end
        // Pin 0 has stood low since channel 0 was cleared, before capture is enabled.
        for (int e = 1; e < 4; e++) begin
            bus(1'b1, tcc_pkg::IDX_CH0, {4'h0, e[1:0], 2'h0});
            pin0(1'b1);
            bus(1'b0, tcc_pkg::IDX_CH0, 8'h00);
            chk(rd & 8'h80, {e[0], 7'h00});
            bus(1'b1, tcc_pkg::IDX_CH0, {4'h0, e[1:0], 2'h0});
            pin0(1'b0);
            bus(1'b0, tcc_pkg::IDX_CH0, 8'h00);
            chk(rd & 8'h80, {e[1], 7'h00});
            bus(1'b1, tcc_pkg::IDX_CH0, {4'h0, e[1:0], 2'h0});
        end
        counter_halt <= 1'b1;
        pin0(1'b1);
        bus(1'b0, tcc_pkg::IDX_CH0, 8'h00);
        chk(rd, 8'h0C);
        counter_halt <= 1'b0;
        pin0(1'b0);
        bus(1'b0, tcc_pkg::IDX_CH0, 8'h00);
        chk(rd, 8'h8C);
        pin0(1'b1);
        bus(1'b1, tcc_pkg::IDX_CH0, 8'h4C);
        waitn(2);
        chk({7'h00, irq[0]}, 8'h01);
        bus(1'b1, tcc_pkg::IDX_CH0, 8'h8C);
        waitn(2);
        chk({7'h00, irq[0]}, 8'h00);
        bus(1'b0, tcc_pkg::IDX_CH0, 8'h00);
        chk(rd, 8'h8C);
        bus(1'b1, tcc_pkg::IDX_CH0, 8'h4C);
        waitn(2);
        chk({7'h00, irq[0]}, 8'h00);
        bus(1'b1, tcc_pkg::IDX_CH0, 8'h00);
        // The first two mode changes on channel 2 happen with the counter halted.
        counter_halt <= 1'b1;
        bus(1'b1, tcc_pkg::IDX_CH2, 8'h10);
        waitn(3);
        chk({7'h00, pin_oe[2]}, 8'h00);
        bus(1'b1, tcc_pkg::IDX_CH2, 8'h1C);
        counter_halt <= 1'b0;
        waitn(3);
        chk({6'h00, pin_oe[2], pin_out[2]}, 8'h02);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, tcc_pkg::IDX_CH2, codes[i]);
            cnt(16'h0010, 1'b0);
            chk({7'h00, pin_out[2]}, {7'h00, ~i[0]});
            bus(1'b0, tcc_pkg::IDX_CH2, 8'h00);
            chk(rd & 8'h80, 8'h80);
        end
        bus(1'b1, tcc_pkg::IDX_CH2, 8'h1E);
        cnt(16'h0000, 1'b1);
        chk({7'h00, pin_out[2]}, 8'h01);
        cnt(16'h0010, 1'b1);
        chk({7'h00, pin_out[2]}, 8'h00);
        bus(1'b1, tcc_pkg::IDX_CH3, 8'h1C);
        bus(1'b1, tcc_pkg::IDX_CH2, 8'h2C);
        waitn(3);
        chk({6'h00, pin_oe[3], pin_oe[2]}, 8'h01);
        bus(1'b0, tcc_pkg::IDX_CH3, 8'h00);
        chk(rd, 8'h00);
        cnt(16'h0010, 1'b0);
        chk({7'h00, pin_out[2]}, 8'h01);
        bus(1'b1, tcc_pkg::IDX_CH2, 8'h19);
        cnt(16'h0000, 1'b1);
        cnt(16'h0010, 1'b0);
        chk({7'h00, pin_out[2]}, 8'h01);
        rstn <= 1'b0;
        waitn(2);
        rstn <= 1'b1;
        waitn(1);
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, tcc_pkg::CH_IDX[i], 8'h00);
            chk(rd, 8'h00);
        end
        bus(1'b0, tcc_pkg::IDX_STATE, 8'h00);
        chk(rd, 8'h3F);
        chk({2'h0, irq}, 8'h00);
        chk({7'h00, hresp}, 8'h00);
        test_done();
    end
endmodule
